/* design/power_switch_params.svh */
// Constants for the power switch mode sequencer.
// How it works
// - Lockout keeps everything off until both supplies good.
// - Main supply above rise level enters normal.
// - Main supply below fall level returns lockout.
// - Switch follows pulse input in normal mode.
// - Current sense valid only during switch on-time.
// - Quiet pulse input for timeout enters standby.
// - Standby keeps gate drive and circuitry off.
// - First pulse rising edge wakes standby immediately.
// - Standby select high blocks standby entry but does not end standby.
`ifndef POWER_SWITCH_PARAMS_SVH
`define POWER_SWITCH_PARAMS_SVH
`define CLK_PERIOD_PS 5000
`define STANDBY_TIMEOUT_NS 90000
`define STANDBY_TIMEOUT_CYCLES ((`STANDBY_TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)
`define TIMEOUT_CNT_W 16
`endif

/* design/power_switch_pkg.sv */
// Types shared by the power switch mode sequencer.
package power_switch_pkg;
  typedef enum logic [1:0] {
    supply_lockout_mode,
    normal_mode,
    standby_mode
  } mode_t;
endpackage

/* design/sync2.sv */
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module sync2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // First flop feeds only the second flop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* design/power_switch_mode_sequencer.sv */
// Mode sequencer driving the power switch gate from supply and pulse inputs.
`timescale 1ns/10ps
`include "power_switch_params.svh"
module power_switch_mode_sequencer #(
  parameter int unsigned STANDBY_TIMEOUT_CYCLES = `STANDBY_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic main_supply_rise_level,
  input wire logic main_supply_fall_level,
  input wire logic driver_supply_rise_level,
  input wire logic pulse_in,
  input wire logic auto_standby_select_n,
  output logic gate_drive_on,
  output logic sense_enable,
  output logic circuits_enable,
  output power_switch_pkg::mode_t mode
);
  import power_switch_pkg::*;

  // Overview of the behaviour.
  // The sequencer has three modes: supply lockout, normal and standby.
  // Reset always lands in supply lockout, with every output low.
  // Lockout is left only when both the main supply and the driver supply
  // report that they are above their rising levels.
  // Once out of lockout, only the main supply fall level can send the block
  // back, so a driver supply dip alone does not force a lockout.
  // In normal mode the gate follows the synchronised pulse input level.
  // The current sense enable is raised exactly when the gate is on.
  // A quiet pulse input, held low for the whole standby timeout, moves the
  // block to standby, but only while the standby select pin is low.
  // In standby the gate, sense and circuits enables are low until the first rising pulse edge.
  // That edge takes the block straight back to normal mode, and the same
  // clock edge that updates the mode also turns the gate on.

  // Latency notes.
  // Every pin passes two flip-flops before any logic reads it.
  // The mode and the registered outputs change one clock later again.
  // A pin change therefore shows at the outputs two clocks after it is
  // first sampled, which users of the block must allow for.
  // Pulses shorter than a clock period may be missed altogether; the
  // pulse source is expected to be much slower than the clock.

  // Hazards that the structure avoids.
  // Outputs are decided from the next mode, not the current one, so they
  // never show a stale on state for one cycle while the mode leaves normal.
  // The edge detector resets low, matching the idle level of the pulse pin,
  // so no false wake edge can appear just after reset.
  // The timeout counter saturates at its last value, so a long quiet spell
  // with standby forbidden cannot wrap and restart the count.

  // Number of pin inputs that cross into the clock domain.
  localparam int unsigned N_PINS = 5;
  // Position of each pin inside the synchronised vector.
  localparam int unsigned PIN_MAIN_RISE = 0;
  localparam int unsigned PIN_MAIN_FALL = 1;
  localparam int unsigned PIN_DRV_RISE = 2;
  localparam int unsigned PIN_PULSE = 3;
  localparam int unsigned PIN_AUTO_STANDBY_SELECT_N_N = 4;

  localparam logic [`TIMEOUT_CNT_W-1:0] TIMEOUT_LAST =
    `TIMEOUT_CNT_W'(STANDBY_TIMEOUT_CYCLES - 1);

  logic [N_PINS-1:0] pins_raw;
  logic [N_PINS-1:0] pins_s;
  logic main_rise_s;
  logic main_fall_s;
  logic drv_rise_s;
  logic pulse_s;
  logic auto_standby_select_n_n_s;
  logic pulse_prev_q;
  logic pulse_rise;
  logic timeout_hit;
  logic [`TIMEOUT_CNT_W-1:0] quiet_cnt_q;
  mode_t mode_q;
  mode_t mode_d;

  // Tells whether a mode is the one in which the switch may conduct.
  function automatic logic is_normal(input mode_t m);
    is_normal = (m == normal_mode);
  endfunction

  // Decides whether the switch conducts for a given mode and pulse level.
  function automatic logic switch_on(input mode_t m, input logic pulse_lvl);
    switch_on = is_normal(m) && pulse_lvl;
  endfunction

  // Gather the asynchronous pin levels into one vector.
  assign pins_raw[PIN_MAIN_RISE] = main_supply_rise_level;
  assign pins_raw[PIN_MAIN_FALL] = main_supply_fall_level;
  assign pins_raw[PIN_DRV_RISE] = driver_supply_rise_level;
  assign pins_raw[PIN_PULSE] = pulse_in;
  assign pins_raw[PIN_AUTO_STANDBY_SELECT_N_N] = auto_standby_select_n;

  // Bring every pin level into the clock domain through two flops each.
  for (genvar g = 0; g < N_PINS; g++) begin : g_sync
    sync2 u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(pins_raw[g]),
      .sync_out(pins_s[g])
    );
  end

  // Name the synchronised levels for the logic below.
  assign main_rise_s = pins_s[PIN_MAIN_RISE];
  assign main_fall_s = pins_s[PIN_MAIN_FALL];
  assign drv_rise_s = pins_s[PIN_DRV_RISE];
  assign pulse_s = pins_s[PIN_PULSE];
  assign auto_standby_select_n_n_s = pins_s[PIN_AUTO_STANDBY_SELECT_N_N];

  // Previous pulse level for rising edge detection.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_prev_q <= 1'b0;
    end else begin
      pulse_prev_q <= pulse_s;
    end
  end

  assign pulse_rise = pulse_s && !pulse_prev_q;
  assign timeout_hit = (quiet_cnt_q == TIMEOUT_LAST) && !pulse_s;

  // Quiet timer restart.
  // Counts consecutive low cycles of the pulse input while in normal mode.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_cnt_q <= '0;
    end else if (pulse_s || !is_normal(mode_q)) begin
      quiet_cnt_q <= '0;
    end else if (quiet_cnt_q != TIMEOUT_LAST) begin
      quiet_cnt_q <= quiet_cnt_q + `TIMEOUT_CNT_W'(1);
    end
  end

  // Next mode; lockout conditions are checked first.
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      supply_lockout_mode: begin
        if (main_rise_s && drv_rise_s) begin
          mode_d = normal_mode;
        end
      end
      normal_mode: begin
        if (!main_fall_s) begin
          mode_d = supply_lockout_mode;
        end else if (timeout_hit && !auto_standby_select_n_n_s) begin
          mode_d = standby_mode;
        end
      end
      standby_mode: begin
        if (!main_fall_s) begin
          mode_d = supply_lockout_mode;
        end else if (pulse_rise) begin
          mode_d = normal_mode;
        end
      end
      default: begin
        mode_d = supply_lockout_mode;
      end
    endcase
  end

  // Mode register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= supply_lockout_mode;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Registered outputs follow the mode and pulse input.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_drive_on <= 1'b0;
      sense_enable <= 1'b0;
      circuits_enable <= 1'b0;
    end else begin
      gate_drive_on <= switch_on(mode_d, pulse_s);
      sense_enable <= switch_on(mode_d, pulse_s);
      circuits_enable <= is_normal(mode_d);
    end
  end

  assign mode = mode_q;
endmodule

/* verification/seq_sva.sv */
// Port assertions for the mode sequencer.
`timescale 1ns/10ps
module seq_sva #(
  parameter int unsigned STANDBY_TIMEOUT_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic main_supply_rise_level,
  input wire logic main_supply_fall_level,
  input wire logic driver_supply_rise_level,
  input wire logic pulse_in,
  input wire logic auto_standby_select_n,
  input wire logic gate_drive_on,
  input wire logic sense_enable,
  input wire logic circuits_enable,
  input wire power_switch_pkg::mode_t mode
);
  import power_switch_pkg::*;
  int unsigned quiet_q;
  logic quiet_now;
  logic all_up;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A cycle is quiet while standby is allowed and the mode is normal.
  assign quiet_now = !pulse_in && !auto_standby_select_n && (mode == normal_mode);
  // Both supplies above their rising levels and the main one above its fall level.
  assign all_up = main_supply_rise_level && main_supply_fall_level && driver_supply_rise_level;
  // Counts quiet pulse cycles while standby is allowed in normal mode.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quiet_q <= 0;
    end else begin
      quiet_q <= quiet_now ? quiet_q + 1 : 0;
    end
  end
  sequence pulse_back;
    mode == standby_mode ##1 pulse_in [*5];
  endsequence
  chk_off_outside: assert property (mode != normal_mode |-> !gate_drive_on && !circuits_enable)
    else $error("outputs on outside normal");
  chk_supply_up: assert property (all_up [*5] |-> mode != supply_lockout_mode)
    else $error("no lockout exit");
  chk_fall_lock: assert property (!main_supply_fall_level [*5]
    |-> mode == supply_lockout_mode)
    else $error("no lockout on fall");
  chk_gate_follow: assert property ((mode == normal_mode && $stable(pulse_in)) [*5]
    |-> gate_drive_on == pulse_in)
    else $error("gate not following");
  chk_sense_pair: assert property (sense_enable == gate_drive_on)
    else $error("sense mismatch");
  chk_standby_late: assert property (quiet_q <= STANDBY_TIMEOUT_CYCLES + 4)
    else $error("standby late");
  chk_wake_fast: assert property (pulse_back |-> mode == normal_mode && gate_drive_on)
    else $error("wake slow");
  chk_no_standby: assert property (auto_standby_select_n [*5] ##1 mode != standby_mode
    |=> mode != standby_mode)
    else $error("standby while forbidden");
endmodule
bind power_switch_mode_sequencer seq_sva #(.STANDBY_TIMEOUT_CYCLES(STANDBY_TIMEOUT_CYCLES)) sva (.*);

/* verification/pwm_src.sv */
// Pulse source standing in for the converter controller.
`timescale 1ns/10ps
module pwm_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] hi,
  input wire logic [3:0] lo,
  output logic pulse
);
  logic [3:0] cnt_q;
  // Toggles after hi+1 or lo+1 cycles and rests low when stopped.
  always_ff @(posedge clk) begin
    cnt_q <= (!run || cnt_q >= (pulse ? hi : lo)) ? 4'h0 : cnt_q + 4'h1;
    pulse <= run && ((cnt_q >= (pulse ? hi : lo)) ? !pulse : pulse);
  end
endmodule

/* verification/tb_power_switch_mode_sequencer.sv */
// Self-checking bench for the mode sequencer.
`timescale 1ns/10ps
module tb_power_switch_mode_sequencer;
  import power_switch_pkg::*;
  logic clk, rstn, mr, mf, dr, sel_n, run, pulse, gate, sense, circ;
  logic [3:0] hi, lo;
  logic [15:0] lf_q = 16'h549c;
  mode_t mode;
  int n_errors = 0, n_tests = 0;
  power_switch_mode_sequencer #(.STANDBY_TIMEOUT_CYCLES(12)) dut (.clk(clk), .rstn(rstn),
    .main_supply_rise_level(mr), .main_supply_fall_level(mf), .driver_supply_rise_level(dr),
    .pulse_in(pulse), .auto_standby_select_n(sel_n), .gate_drive_on(gate),
    .sense_enable(sense), .circuits_enable(circ), .mode(mode));
  pwm_src ctl (.clk(clk), .run(run), .hi(hi), .lo(lo), .pulse(pulse));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic mode_t exp_mode(input logic up, input logic quiet);
    return !up ? supply_lockout_mode : (quiet ? standby_mode : normal_mode);
  endfunction
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
    $display("test %s done", n);
  endtask
  task automatic close_out();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Clock and a watchdog that cuts a hang short.
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #6000;
    n_errors++;
    close_out();
  end
  // Inputs change at rising edges; outputs are checked one ns later.
  initial begin
    {rstn, mr, mf, dr, sel_n, run, hi, lo} = '0;
    tk(10);
    rstn <= 1'b1;
    dr <= 1'b1;
    tk(8);
    mr <= 1'b1;
    mf <= 1'b1;
    #1 chk("lockout", exp_mode(0, 0), mode);
    tk(5);
    hi <= 4'h5;
    lo <= 4'h4;
    run <= 1'b1;
    #1 chk("normal", exp_mode(1, 0), mode);
    chk("circuits", 2'h1, circ);
    for (int i = 0; i < 20; i++) begin
      tk(12);
      lf_q = lfsr_next(lf_q);
      hi <= 4'h5 + {2'b0, lf_q[1:0]};
      lo <= 4'h4 + {2'b0, lf_q[3:2]};
    end
    // Wait for a fresh rising edge of the pulse so the high phase is long enough.
    while (pulse) tk(1);
    while (!pulse) tk(1);
    tk(4);
    #1 chk("gate", 2'h1, gate);
    chk("sense", 2'h1, sense);
    tk(1);
    run <= 1'b0;
    tk(22);
    #1 chk("standby", exp_mode(1, 1), mode);
    chk("standby gate", 2'h0, gate | circ);
    tk(1);
    run <= 1'b1;
    tk(14);
    #1 chk("wake", exp_mode(1, 0), mode);
    tk(1);
    sel_n <= 1'b1;
    run <= 1'b0;
    tk(40);
    mf <= 1'b0;
    mr <= 1'b0;
    #1 chk("forbid", exp_mode(1, 0), mode);
    tk(6);
    #1 chk("fall", exp_mode(0, 0), mode);
    close_out();
  end
endmodule
